// File: pkg/field_mark_pkg.sv
// package for the scaler output field marking block
// assumes one clock domain and an AXI4-Lite master with 8-bit byte addresses
package field_mark_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_GLOBAL = 8'h80;
   localparam logic [7:0] OFF_RESET = 8'h88;
   localparam logic [7:0] OFF_TASK_A = 8'h90;
   localparam logic [7:0] OFF_PIN_SEL = 8'ha0;
   localparam logic [7:0] OFF_STATUS = 8'ha4;
   localparam logic [7:0] OFF_TASK_B = 8'hc0;

   // field positions
   localparam int TASK_A_EN_BIT = 4;
   localparam int TASK_B_EN_BIT = 5;
   localparam int SOFT_RST_BIT = 5;
   localparam int FIELD_SRC_BIT = 6;
   localparam int D7_INV_BIT = 7;
   localparam int PIN_A_LSB = 0;
   localparam int PIN_B_LSB = 2;

   // reset values
   localparam logic [7:0] GLOBAL_RST = 8'h00;
   localparam logic [7:0] RESET_RST = 8'h20;
   localparam logic [7:0] TASK_RST = 8'h00;
   localparam logic [7:0] PIN_SEL_RST = 8'h00;

   // pin function codes
   localparam logic [1:0] PIN_OFF = 2'h0;
   localparam logic [1:0] PIN_FIELD = 2'h1;
   localparam logic [1:0] PIN_TASK = 2'h2;
   localparam logic [1:0] PIN_TOGGLE = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int FIFO_DEPTH = 8;
   localparam int CODE_W = 8;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axil_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_type;

   typedef struct packed {
      logic eav;
      logic vblank;
   } code_req_type;

   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] global_reg;
      logic [7:0] reset_reg;
      logic [7:0] task_a_reg;
      logic [7:0] task_b_reg;
      logic [7:0] pin_sel_reg;
      logic [1:0] toggle;
      logic active_b;
      logic prio_b;
      logic field_out;
      logic toggle_out;
      logic pin_a;
      logic pin_b;
   } mark_state_type;

   // timing reference byte: 1 F V H P3 P2 P1 P0, with D7 selectable
   function automatic logic [7:0] make_code(input logic d7, input logic f,
                                            input logic v, input logic h);
      make_code = {d7, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
   endfunction : make_code

endpackage : field_mark_pkg

// File: core/scaler_output_field_marking.sv
// output field marking for the scaler port, with its code FIFO
// assumes task handler pulses and field id come from logic on clk
`timescale 1ns/10ps

module code_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // depth must be a power of two so the pointers wrap by themselves
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [CW-1:0] count;
   } fifo_state_type;

   fifo_state_type s_q;
   fifo_state_type s_d;
   logic push;
   logic pop;

   // ***************************************************************
   // push and pop
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      in_ready = (s_q.count != CW'(DEPTH));
      out_valid = (s_q.count != '0);
      out_data = s_q.mem[s_q.rd_ptr];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = in_data;
         s_d.wr_ptr = PW'(s_q.wr_ptr + 1'b1);
      end
      if (pop) begin
         s_d.rd_ptr = PW'(s_q.rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         s_d.count = CW'(s_q.count + 1'b1);
      end else if (pop && !push) begin
         s_d.count = CW'(s_q.count - 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : code_fifo

module scaler_output_field_marking (
   input wire logic clk,
   input wire logic rst_n,
   input wire field_mark_pkg::axil_req_type axi_req,
   output field_mark_pkg::axil_rsp_type axi_rsp,
   input wire logic field_identifier,
   input wire logic task_activate,
   input wire logic task_a_pending,
   input wire logic task_b_pending,
   output logic task_grant_a,
   output logic task_grant_b,
   input wire logic code_valid,
   output logic code_ready,
   input wire field_mark_pkg::code_req_type code_req,
   output logic tc_valid,
   input wire logic tc_ready,
   output logic [7:0] tc_byte,
   output logic out_field_id,
   output logic field_toggle,
   output logic gp_out_pin_a,
   output logic gp_out_pin_b
);
   field_mark_pkg::mark_state_type s_q;
   field_mark_pkg::mark_state_type s_d;
   logic soft_rst;
   logic en_a;
   logic en_b;
   logic both;
   logic [7:0] cfg;
   logic tog;
   logic field_now;
   logic d7_now;
   logic [7:0] push_byte;
   logic [7:0] wr_val;
   logic [7:0] rd_val;
   logic rd_ok;
   logic wr_ok;

   // every check below runs on clk and sleeps through the pin reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // pin function mux, shared by both general purpose pins
   function automatic logic pin_fn(input logic [1:0] sel, input logic fld,
                                   input logic d7, input logic tg);
      case (sel)
         field_mark_pkg::PIN_FIELD: pin_fn = fld;
         field_mark_pkg::PIN_TASK: pin_fn = d7;
         field_mark_pkg::PIN_TOGGLE: pin_fn = tg;
         default: pin_fn = 1'b0;
      endcase
   endfunction : pin_fn

   // ***************************************************************
   // register bus, task arbitration and marking
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      wr_val = s_q.w_data;
      rd_val = 8'h00;
      rd_ok = 1'b1;
      wr_ok = 1'b1;
      // soft reset bit low holds the marking state machines idle
      soft_rst = !s_q.reset_reg[field_mark_pkg::SOFT_RST_BIT];
      en_a = s_q.global_reg[field_mark_pkg::TASK_A_EN_BIT];
      en_b = s_q.global_reg[field_mark_pkg::TASK_B_EN_BIT];
      // settings of whichever task last started
      cfg = s_q.active_b ? s_q.task_b_reg : s_q.task_a_reg;
      tog = s_q.toggle[s_q.active_b];
      // zero on the field id marks the first field, passed on unchanged while the task's bit 6 is clear
      field_now = cfg[field_mark_pkg::FIELD_SRC_BIT] ? tog
                  : field_identifier;
      d7_now = !cfg[field_mark_pkg::D7_INV_BIT];
      push_byte = field_mark_pkg::make_code(d7_now, field_now, code_req.vblank, code_req.eav);

      // write channel: address and data taken in either order
      axi_rsp.awready = !s_q.aw_held;
      axi_rsp.wready = !s_q.w_held;
      if (axi_req.awvalid && !s_q.aw_held) begin
         s_d.aw_held = 1'b1;
         s_d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !s_q.w_held) begin
         s_d.w_held = 1'b1;
         s_d.w_data = axi_req.wdata[7:0];
         s_d.w_lane0 = axi_req.wstrb[0];
      end
      if (s_q.bvalid && axi_req.bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
         s_d.aw_held = 1'b0;
         s_d.w_held = 1'b0;
         s_d.bvalid = 1'b1;
         case (s_q.aw_addr)
            field_mark_pkg::OFF_GLOBAL: if (s_q.w_lane0) s_d.global_reg = wr_val;
            field_mark_pkg::OFF_RESET: if (s_q.w_lane0) s_d.reset_reg = wr_val;
            field_mark_pkg::OFF_TASK_A: if (s_q.w_lane0) s_d.task_a_reg = wr_val;
            field_mark_pkg::OFF_TASK_B: if (s_q.w_lane0) s_d.task_b_reg = wr_val;
            field_mark_pkg::OFF_PIN_SEL: if (s_q.w_lane0) s_d.pin_sel_reg = wr_val;
            field_mark_pkg::OFF_STATUS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
         endcase
         s_d.bresp = wr_ok ? field_mark_pkg::RESP_OKAY : field_mark_pkg::RESP_SLVERR;
      end

      // read channel: answer registered one edge after the address
      case (axi_req.araddr)
         field_mark_pkg::OFF_GLOBAL: rd_val = s_q.global_reg;
         field_mark_pkg::OFF_RESET: rd_val = s_q.reset_reg;
         field_mark_pkg::OFF_TASK_A: rd_val = s_q.task_a_reg;
         field_mark_pkg::OFF_TASK_B: rd_val = s_q.task_b_reg;
         field_mark_pkg::OFF_PIN_SEL: rd_val = s_q.pin_sel_reg;
         field_mark_pkg::OFF_STATUS: rd_val = {2'h0, s_q.prio_b, s_q.field_out,
                                               field_identifier, s_q.active_b, s_q.toggle};
         default: rd_ok = 1'b0;
      endcase
      axi_rsp.arready = !s_q.rvalid;
      if (s_q.rvalid && axi_req.rready) begin
         s_d.rvalid = 1'b0;
      end
      if (axi_req.arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = {24'h000000, rd_val};
         s_d.rresp = rd_ok ? field_mark_pkg::RESP_OKAY : field_mark_pkg::RESP_SLVERR;
      end

      // task start: b first after soft reset, else the other task
      both = task_a_pending && en_a && task_b_pending && en_b;
      task_grant_b = task_activate && !soft_rst && task_b_pending && en_b
                     && (!both || s_q.prio_b || !s_q.active_b);
      task_grant_a = task_activate && !soft_rst && task_a_pending && en_a && !task_grant_b;
      // toggle moves only on activation or soft reset, never on field detection
      if (soft_rst) begin
         s_d.toggle = 2'b00;
         s_d.prio_b = 1'b1;
         s_d.active_b = 1'b0;
      end else if (task_grant_b) begin
         s_d.toggle[1] = !s_q.toggle[1];
         s_d.active_b = 1'b1;
         s_d.prio_b = 1'b0;
      end else if (task_grant_a) begin
         s_d.toggle[0] = !s_q.toggle[0];
         s_d.active_b = 1'b0;
         s_d.prio_b = 1'b0;
      end

      // registered field reference and pins
      s_d.field_out = field_now;
      s_d.toggle_out = tog;
      s_d.pin_a = pin_fn(s_q.pin_sel_reg[field_mark_pkg::PIN_A_LSB +: 2],
                         field_now, d7_now, tog);
      s_d.pin_b = pin_fn(s_q.pin_sel_reg[field_mark_pkg::PIN_B_LSB +: 2],
                         field_now, d7_now, tog);

      axi_rsp.bvalid = s_q.bvalid;
      axi_rsp.bresp = s_q.bresp;
      axi_rsp.rvalid = s_q.rvalid;
      axi_rsp.rdata = s_q.rdata;
      axi_rsp.rresp = s_q.rresp;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.global_reg <= field_mark_pkg::GLOBAL_RST;
         s_q.reset_reg <= field_mark_pkg::RESET_RST;
         s_q.task_a_reg <= field_mark_pkg::TASK_RST;
         s_q.task_b_reg <= field_mark_pkg::TASK_RST;
         s_q.pin_sel_reg <= field_mark_pkg::PIN_SEL_RST;
         s_q.prio_b <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign out_field_id = s_q.field_out;
   assign field_toggle = s_q.toggle_out;
   assign gp_out_pin_a = s_q.pin_a;
   assign gp_out_pin_b = s_q.pin_b;

   // ***************************************************************
   // timing code buffer; a stalled sink holds back code requests
   // ***************************************************************
   code_fifo #(
      .WIDTH(field_mark_pkg::CODE_W),
      .DEPTH(field_mark_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(code_valid),
      .in_ready(code_ready),
      .in_data(push_byte),
      .out_valid(tc_valid),
      .out_ready(tc_ready),
      .out_data(tc_byte)
   );

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_toggle_flip_a;
      task_grant_a |=> (s_q.toggle[0] != $past(s_q.toggle[0])) && !s_q.active_b;
   endproperty
   a_toggle_flip_a: assert property (p_toggle_flip_a) else $error("a toggle stuck");

   property p_toggle_quiet;
      !task_grant_a && !task_grant_b && !soft_rst && !$past(soft_rst) |=> $stable(s_q.toggle);
   endproperty
   a_toggle_quiet: assert property (p_toggle_quiet) else $error("toggle moved idle");

   property p_d6_source;
      code_valid && code_ready |-> push_byte[6] ==
         (cfg[field_mark_pkg::FIELD_SRC_BIT] ? s_q.toggle[s_q.active_b] : field_identifier);
   endproperty
   a_d6_source: assert property (p_d6_source) else $error("wrong field bit in code");

   property p_d7_value;
      code_valid && code_ready |-> push_byte[7] != cfg[field_mark_pkg::D7_INV_BIT];
   endproperty
   a_d7_value: assert property (p_d7_value) else $error("wrong d7 in code");

   property p_b_first;
      s_q.prio_b && task_activate && both && !soft_rst |-> task_grant_b ##1 s_q.active_b;
   endproperty
   a_b_first: assert property (p_b_first) else $error("task b lost first start");

   property p_soft_clear;
      soft_rst |=> s_q.toggle == 2'b00 ##1 field_toggle == 1'b0 || !soft_rst;
   endproperty
   a_soft_clear: assert property (p_soft_clear) else $error("soft reset kept toggle");

   property p_pin_task;
      s_q.pin_sel_reg[1:0] == field_mark_pkg::PIN_TASK |=> gp_out_pin_a == $past(d7_now);
   endproperty
   a_pin_task: assert property (p_pin_task) else $error("pin a not task flag");

   property p_field_pass;
      !cfg[field_mark_pkg::FIELD_SRC_BIT] |=> out_field_id == $past(field_identifier);
   endproperty
   a_field_pass: assert property (p_field_pass) else $error("field id not passed");

   property p_rvalid_hold;
      axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
   endproperty
   a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped");

   property p_toggle_flip_b;
      task_grant_b |=> (s_q.toggle[1] != $past(s_q.toggle[1])) && s_q.active_b;
   endproperty
   a_toggle_flip_b: assert property (p_toggle_flip_b) else $error("b toggle stuck");

   property p_soft_block;
      soft_rst |-> !task_grant_a && !task_grant_b;
   endproperty
   a_soft_block: assert property (p_soft_block) else $error("start in soft reset");

   // the back end samples this flag, so it must track the active task's toggle
   property p_toggle_out;
      !soft_rst |=> field_toggle == $past(s_q.toggle[s_q.active_b]);
   endproperty
   a_toggle_out: assert property (p_toggle_out) else $error("toggle output stale");

   property p_code_hold;
      tc_valid && !tc_ready |=> tc_valid && $stable(tc_byte);
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("code byte dropped");

   c_both_tasks: cover property (task_grant_b ##[1:50] task_grant_a);
   c_fifo_full: cover property (code_valid && !code_ready);
   c_toggle_src: cover property (cfg[field_mark_pkg::FIELD_SRC_BIT] && code_valid && code_ready);
   c_soft_block: cover property (soft_rst && task_activate && task_a_pending);
endmodule : scaler_output_field_marking

// File: tb/backend_sink.sv
// back end capture model that drains the timing code stream
// assumes the stream handshake of the marking block and a single clock
`timescale 1ns/10ps

module backend_sink (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic tc_valid,
   input wire logic [7:0] tc_byte,
   output logic tc_ready,
   output logic code_bad
);
   logic [3:0] prot;

   // protection bits the back end expects from the F, V and H bits
   assign prot = {tc_byte[5] ^ tc_byte[4], tc_byte[6] ^ tc_byte[4],
                  tc_byte[6] ^ tc_byte[5], tc_byte[6] ^ tc_byte[5] ^ tc_byte[4]};

   // ***************************************************************
   // capture
   // ***************************************************************
   // random back pressure, so the fifo never sees a kind consumer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tc_ready <= 1'b0;
         code_bad <= 1'b0;
      end else begin
         tc_ready <= !stall && ($urandom_range(3, 0) != 0);
         // a code with broken protection would be dropped by real capture logic
         if (tc_valid && tc_ready && tc_byte[3:0] != prot) code_bad <= 1'b1;
      end
   end
endmodule : backend_sink

// File: tb/scaler_output_field_marking_tb.sv
// self-checking bench for the scaler output field marking block
// assumes the design package, the design and the back end sink are compiled first
`timescale 1ns/10ps

module scaler_output_field_marking_tb;
   logic clk, rst_n, fld_in, t_act, pa, pb, cv, stall;
   field_mark_pkg::axil_req_type req;
   field_mark_pkg::axil_rsp_type rsp;
   field_mark_pkg::code_req_type creq;
   logic ga, gb, code_ready, tc_valid, tc_ready, out_fld, ftog, pin_a, pin_b, code_bad;
   logic [7:0] tc_byte, ca, cb;
   logic [7:0] exq[$];
   logic [7:0] offs [5] = '{8'h80, 8'h88, 8'h90, 8'ha0, 8'hc0};
   logic [7:0] rsts [5] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
   logic [1:0] tog;
   logic last_b, prio_b, srst;
   int n_fail, n_tests, cyc;

   scaler_output_field_marking dut_u (.clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
      .field_identifier(fld_in), .task_activate(t_act), .task_a_pending(pa), .task_b_pending(pb),
      .task_grant_a(ga), .task_grant_b(gb), .code_valid(cv), .code_ready(code_ready),
      .code_req(creq), .tc_valid(tc_valid), .tc_ready(tc_ready), .tc_byte(tc_byte),
      .out_field_id(out_fld), .field_toggle(ftog), .gp_out_pin_a(pin_a), .gp_out_pin_b(pin_b));
   backend_sink sink_u (.clk(clk), .rst_n(rst_n), .stall(stall), .tc_valid(tc_valid),
      .tc_byte(tc_byte), .tc_ready(tc_ready), .code_bad(code_bad));

   // ***************************************************************
   // clock, timeout and checks
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         tally_and_finish;
      end
   end

   // output watcher: oldest note against every byte taken by the sink
   always @(posedge clk) begin
      if (rst_n === 1'b1 && tc_valid === 1'b1 && tc_ready === 1'b1) begin
         chk("code_byte", exq.pop_front(), tc_byte);
      end
   end

   // ***************************************************************
   // bus and stimulus tasks
   // ***************************************************************
   task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic bd;
      bd = 1'b0;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= {24'h000000, d};
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      while (!bd) begin
         @(posedge clk);
         if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
         if (req.bready && rsp.bvalid === 1'b1) begin
            bd = 1'b1;
            req.bready <= 1'b0;
            chk("bresp", {6'h00, er}, {6'h00, rsp.bresp});
         end
      end
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
      logic rd;
      rd = 1'b0;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      while (!rd) begin
         @(posedge clk);
         if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
         if (req.rready && rsp.rvalid === 1'b1) begin
            rd = 1'b1;
            req.rready <= 1'b0;
            d = rsp.rdata[7:0];
            r = rsp.rresp;
         end
      end
   endtask : axr

   // one activation; grant seen in the same cycle, toggle two edges later
   task automatic act(input logic a, input logic b);
      logic eb, eg;
      @(posedge clk);
      t_act <= 1'b1;
      pa <= a;
      pb <= b;
      eg = !srst && (a || b);
      eb = (a && b) ? (prio_b || !last_b) : b;
      @(posedge clk);
      chk("grant_a", {7'h00, eg && !eb}, {7'h00, ga});
      chk("grant_b", {7'h00, eg && eb}, {7'h00, gb});
      t_act <= 1'b0;
      if (eg) begin
         tog[eb] = !tog[eb];
         last_b = eb;
         prio_b = 1'b0;
      end
      repeat (2) @(posedge clk);
      chk("toggle", {7'h00, tog[last_b]}, {7'h00, ftog});
   endtask : act

   // note the byte first, then offer it until the fifo takes it
   task automatic push(input logic e, input logic v, input logic f);
      logic [7:0] c;
      logic x;
      c = last_b ? cb : ca;
      x = c[6] ? tog[last_b] : f;
      exq.push_back({!c[7], x, v, e, v ^ e, x ^ e, x ^ v, x ^ v ^ e});
      @(posedge clk);
      cv <= 1'b1;
      creq <= {e, v};
      fld_in <= f;
      do @(posedge clk); while (code_ready !== 1'b1);
      cv <= 1'b0;
   endtask : push

   // pins lag the field bit by one register, so allow a few cycles
   task automatic pins(input logic [1:0] p, input logic f);
      logic [7:0] c;
      logic x, ep;
      axw(field_mark_pkg::OFF_PIN_SEL, {4'h0, p, p}, field_mark_pkg::RESP_OKAY);
      fld_in <= f;
      repeat (4) @(posedge clk);
      c = last_b ? cb : ca;
      x = c[6] ? tog[last_b] : f;
      ep = (p == field_mark_pkg::PIN_OFF) ? 1'b0 : (p == field_mark_pkg::PIN_FIELD) ? x :
         (p == field_mark_pkg::PIN_TASK) ? !c[7] : tog[last_b];
      chk("field_out", {7'h00, x}, {7'h00, out_fld});
      chk("pin_a", {7'h00, ep}, {7'h00, pin_a});
      chk("pin_b", {7'h00, ep}, {7'h00, pin_b});
      chk("toggle_hold", {7'h00, tog[last_b]}, {7'h00, ftog});
   endtask : pins

   task automatic round(input logic [7:0] a, input logic [7:0] b);
      logic ra, rb;
      axw(field_mark_pkg::OFF_TASK_A, a, field_mark_pkg::RESP_OKAY);
      ca = a;
      axw(field_mark_pkg::OFF_TASK_B, b, field_mark_pkg::RESP_OKAY);
      cb = b;
      repeat (10) begin
         ra = 1'($urandom);
         rb = 1'($urandom) | !ra;
         act(ra, rb);
         repeat (2) push(1'($urandom), 1'($urandom), 1'($urandom));
         pins(2'($urandom), 1'($urandom));
      end
   endtask : round

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      logic [7:0] d;
      logic [1:0] r;
      n_fail = 0;
      n_tests = 0;
      cyc = 0;
      rst_n = 1'b0;
      req = '0;
      creq = '0;
      {fld_in, t_act, pa, pb, cv, stall} = 6'h00;
      {tog, last_b, prio_b, srst} = 5'h02;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      void'($urandom(32'h3df036b0));
      foreach (offs[i]) begin
         axr(offs[i], d, r);
         chk("reset_value", rsts[i], d);
      end
      axr(8'h84, d, r);
      chk("unmapped_data", 8'h00, d);
      chk("unmapped_resp", {6'h00, field_mark_pkg::RESP_SLVERR}, {6'h00, r});
      axw(8'h84, 8'h5a, field_mark_pkg::RESP_SLVERR);
      axw(field_mark_pkg::OFF_GLOBAL, 8'h30, field_mark_pkg::RESP_OKAY);
      round(8'h40, 8'hc0);
      round(8'hc0, 8'h40);
      // fill the fifo with the sink stalled, then drain it
      while (exq.size() != 0) @(posedge clk);
      stall <= 1'b1;
      repeat (8) push(1'($urandom), 1'($urandom), 1'($urandom));
      @(posedge clk);
      chk("fifo_full", 8'h00, {7'h00, code_ready});
      stall <= 1'b0;
      while (exq.size() != 0) @(posedge clk);
      repeat (2) @(posedge clk);
      chk("fifo_empty", 8'h00, {7'h00, tc_valid});
      chk("sink_protect", 8'h00, {7'h00, code_bad});
      // soft reset blocks starts and clears toggles; then b wins again
      axw(field_mark_pkg::OFF_RESET, 8'h00, field_mark_pkg::RESP_OKAY);
      {tog, last_b, prio_b, srst} = 5'h03;
      act(1'b1, 1'b1);
      // status while held: toggles clear, task a active, b has priority
      axw(field_mark_pkg::OFF_STATUS, 8'hff, field_mark_pkg::RESP_OKAY);
      axr(field_mark_pkg::OFF_STATUS, d, r);
      chk("status", {3'h1, ca[6] ? 1'b0 : fld_in, fld_in, 3'h0}, d);
      axw(field_mark_pkg::OFF_RESET, 8'h20, field_mark_pkg::RESP_OKAY);
      srst = 1'b0;
      act(1'b1, 1'b1);
      tally_and_finish;
   end
endmodule : scaler_output_field_marking_tb
